// File: pkg/usu_defines.vh
// Constants for the universal serial shift unit
`ifndef USU_DEFINES_VH
`define USU_DEFINES_VH
// ************************************************************
// Widths
// ************************************************************
`define USU_DATA_W 8
`define USU_CNT_W 4
`define USU_CNT_MAX 4'hf
`define USU_DATA_RST 8'h00
`define USU_CNT_RST 4'h0
// ************************************************************
// Wire modes
// ************************************************************
`define USU_WM_NONE 2'h0
`define USU_WM_THREE 2'h1
`define USU_WM_TWO 2'h2
`define USU_WM_TWO_HOLD 2'h3
// ************************************************************
// Receive buffer
// ************************************************************
`define USU_BUF_DEPTH 2
`endif

// File: hw/usu_buf2.v
// Two-entry valid/ready buffer for completed bytes
`timescale 1ns/1ps
`default_nettype none
module usu_buf2 #(
  parameter WIDTH = 8
) (
  input wire clk_sys,
  input wire nrst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // ************************************************************
  // Storage: head entry feeds the output, tail entry catches a stall
  // ************************************************************
  reg [WIDTH-1:0] head_reg;
  reg [WIDTH-1:0] tail_reg;
  reg head_full_reg;
  reg tail_full_reg;
  wire push;
  wire pop;

  assign in_ready = ~tail_full_reg;
  assign out_valid = head_full_reg;
  assign out_data = head_reg;
  assign push = in_valid & ~tail_full_reg;
  assign pop = head_full_reg & out_ready;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      head_reg <= {WIDTH{1'b0}};
      tail_reg <= {WIDTH{1'b0}};
      head_full_reg <= 1'b0;
      tail_full_reg <= 1'b0;
    end else begin
      if (pop) begin
        if (tail_full_reg) begin
          head_reg <= tail_reg;
          tail_full_reg <= 1'b0;
          if (push) begin
            tail_reg <= in_data;
            tail_full_reg <= 1'b1;
          end
        end else if (push) begin
          head_reg <= in_data;
        end else begin
          head_full_reg <= 1'b0;
        end
      end else if (push) begin
        if (head_full_reg) begin
          tail_reg <= in_data;
          tail_full_reg <= 1'b1;
        end else begin
          head_reg <= in_data;
          head_full_reg <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/usu_top.v
// Universal serial shift unit: shift register, edge counter, pins
// Function
// - Eight-bit shift register, direct access, unbuffered
// - Register MSB drives pin chosen by mode
// - Latch moves output on opposite pin clock edge; internal clocks keep it open
// - Serial input always from data input pin
// - Four-bit counter, shared clock, overflow request
// - External clock counts both edges
// - Clock from pin, timer match, software
// - Start condition flag; hold clock low
// - Three-wire SPI mode 0/1, no select
// - Byte exchanged after eight clocks, flag
// - Toggle strobe or port toggles clock
// - Edge select picks sample/shift edges
// - One bit shifted per clock cycle
// - Sixteen edges overflow; wakes idle processor
// - Two-wire start can wake all sleeps
// - Status write clears flag, loads counter
// - Toggle strobe toggles pin, advances counter
// - Alternating writes give half-rate clock
// - Register write beats simultaneous shift
// - Shift by pin, timer or strobe
`timescale 1ns/1ps
`default_nettype none
`include "usu_defines.vh"
module usu_top #(
  parameter DATA_W = `USU_DATA_W,
  parameter CNT_W = `USU_CNT_W
) (
  input wire clk_sys,
  input wire nrst,
  input wire [1:0] wire_mode_select,
  input wire clock_source_select,
  input wire clock_edge_select,
  input wire clock_toggle_strobe,
  input wire shift_clock_strobe,
  input wire timer_match,
  input wire port_clock_toggle,
  input wire clock_drive_enable,
  input wire data_drive_enable,
  input wire data_wr,
  input wire [DATA_W-1:0] data_wdata,
  input wire status_wr,
  input wire status_clear_ovf,
  input wire status_clear_start,
  input wire [CNT_W-1:0] status_cnt_value,
  input wire serial_data_input_pin,
  input wire serial_clock_pin_in,
  output reg serial_clock_pin_out,
  output reg serial_clock_pin_oe_n,
  output reg data_out_pin,
  output reg data_out_pin_oe_n,
  output reg sda_pin_oe_n,
  output reg [DATA_W-1:0] shift_data_register,
  output reg [CNT_W-1:0] counter_value,
  output reg counter_overflow_flag,
  output reg start_condition_flag,
  output reg wake_request,
  output reg rx_valid,
  output reg [DATA_W-1:0] rx_data,
  input wire rx_ready
);
  // ************************************************************
  // Pin synchronisers: change counts when stages two and three agree
  // ************************************************************
  reg [2:0] sck_sync_reg;
  reg [2:0] di_sync_reg;
  reg sck_stable_reg;
  reg di_stable_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sck_sync_reg <= 3'h0;
      di_sync_reg <= 3'h0;
      sck_stable_reg <= 1'b0;
      di_stable_reg <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_pin_in};
      di_sync_reg <= {di_sync_reg[1:0], serial_data_input_pin};
      if (sck_sync_reg[1] == sck_sync_reg[2])
        sck_stable_reg <= sck_sync_reg[2];
      if (di_sync_reg[1] == di_sync_reg[2])
        di_stable_reg <= di_sync_reg[2];
    end
  end
  wire sck_rise;
  wire sck_fall;
  assign sck_rise = (sck_sync_reg[2] == sck_sync_reg[1]) & sck_sync_reg[2] & ~sck_stable_reg;
  assign sck_fall = (sck_sync_reg[2] == sck_sync_reg[1]) & ~sck_sync_reg[2] & sck_stable_reg;
  // ************************************************************
  // Clock source selection
  // ************************************************************
  wire two_wire;
  wire three_wire;
  wire stall;
  wire sample_edge;
  wire shift_evt;
  wire count_evt;
  wire toggle_evt;
  wire setup_level;
  reg push_pend_reg;
  wire buf_in_ready;
  assign two_wire = wire_mode_select[1];
  assign three_wire = (wire_mode_select == `USU_WM_THREE);
  // Internal sources wait while a finished byte cannot enter the buffer;
  // external edges cannot be stalled, so a late reader only loses a copy
  assign stall = push_pend_reg & ~buf_in_ready;
  // Edge select: 0 samples on rise, 1 on fall
  assign sample_edge = clock_edge_select ? sck_fall : sck_rise;
  assign shift_evt = clock_source_select ? sample_edge :
                     (clock_edge_select ? (timer_match & ~stall) :
                     (shift_clock_strobe & ~stall));
  // External clock counts every edge unless counting on the toggle strobe
  assign count_evt = clock_source_select ?
                     (shift_clock_strobe ? (clock_toggle_strobe & ~stall) :
                     (sck_rise | sck_fall)) : shift_evt;
  assign toggle_evt = clock_toggle_strobe | port_clock_toggle;
  assign setup_level = clock_edge_select;
  // ************************************************************
  // Shift register and output latch
  // ************************************************************
  reg out_latch_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift_data_register <= `USU_DATA_RST;
      out_latch_reg <= 1'b0;
    end else begin
      if (data_wr)
        shift_data_register <= data_wdata;
      else if (shift_evt)
        shift_data_register <= {shift_data_register[DATA_W-2:0], di_stable_reg};
      // Pin clock: latch open only in the setup phase, so the pin moves opposite the sample edge; internal clocks keep it open
      if (!clock_source_select || (sck_stable_reg == setup_level))
        out_latch_reg <= shift_data_register[DATA_W-1];
    end
  end
  // ************************************************************
  // Edge counter and flags
  // ************************************************************
  wire sda_fall;
  reg sda_prev_reg;
  wire start_det;
  wire ovf_evt;
  assign sda_fall = sda_prev_reg & ~di_stable_reg;
  assign start_det = two_wire & sda_fall & sck_stable_reg;
  assign ovf_evt = count_evt & (counter_value == `USU_CNT_MAX) & ~(status_wr);
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      counter_value <= `USU_CNT_RST;
      counter_overflow_flag <= 1'b0;
      start_condition_flag <= 1'b0;
      sda_prev_reg <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      sda_prev_reg <= di_stable_reg;
      if (status_wr)
        counter_value <= status_cnt_value;
      else if (count_evt)
        counter_value <= counter_value + {{(CNT_W-1){1'b0}}, 1'b1};
      // Start set beats its clear; a status write blocks the overflow set, so that clear wins
      if (ovf_evt)
        counter_overflow_flag <= 1'b1;
      else if (status_wr && status_clear_ovf)
        counter_overflow_flag <= 1'b0;
      if (start_det)
        start_condition_flag <= 1'b1;
      else if (status_wr && status_clear_start)
        start_condition_flag <= 1'b0;
      wake_request <= ovf_evt | counter_overflow_flag | start_det | start_condition_flag;
    end
  end
  // ************************************************************
  // Completed byte capture into the buffer
  // ************************************************************
  reg [DATA_W-1:0] push_data_reg;
  wire buf_out_valid;
  wire [DATA_W-1:0] buf_out_data;
  wire buf_pop;
  reg out_hold_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      push_pend_reg <= 1'b0;
      push_data_reg <= `USU_DATA_RST;
    end else begin
      if (ovf_evt) begin
        push_pend_reg <= 1'b1;
        push_data_reg <= shift_evt ?
          {shift_data_register[DATA_W-2:0], di_stable_reg} : shift_data_register;
      end else if (buf_in_ready) begin
        push_pend_reg <= 1'b0;
      end
    end
  end
  usu_buf2 #(
    .WIDTH(DATA_W)
  ) u_buf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(push_pend_reg),
    .in_ready(buf_in_ready),
    .in_data(push_data_reg),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );
  // Output stage registered; pops only when the register is empty or taken
  assign buf_pop = buf_out_valid & (~out_hold_reg | rx_ready);
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      out_hold_reg <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= `USU_DATA_RST;
    end else begin
      if (buf_pop) begin
        out_hold_reg <= 1'b1;
        rx_valid <= 1'b1;
        rx_data <= buf_out_data;
      end else if (rx_ready) begin
        out_hold_reg <= 1'b0;
        rx_valid <= 1'b0;
      end
    end
  end
  // ************************************************************
  // Pin drivers
  // ************************************************************
  wire hold_low;
  // Two-wire wait states: after a start, or after overflow in hold mode
  assign hold_low = two_wire & (start_condition_flag |
                    ((wire_mode_select == `USU_WM_TWO_HOLD) & counter_overflow_flag));
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe_n <= 1'b1;
      data_out_pin <= 1'b0;
      data_out_pin_oe_n <= 1'b1;
      sda_pin_oe_n <= 1'b1;
    end else begin
      if (toggle_evt)
        serial_clock_pin_out <= ~serial_clock_pin_out;
      if (two_wire)
        serial_clock_pin_oe_n <= ~(hold_low | (clock_drive_enable & ~serial_clock_pin_out));
      else
        serial_clock_pin_oe_n <= ~clock_drive_enable;
      data_out_pin <= out_latch_reg;
      data_out_pin_oe_n <= ~(three_wire & data_drive_enable);
      // Open drain: pull the data line low only for a zero
      sda_pin_oe_n <= ~(two_wire & data_drive_enable & ~out_latch_reg);
    end
  end
endmodule
`default_nettype wire

// File: bench/usu_monitor.sv
// Checker on the serial shift unit ports
`timescale 1ns/1ps
`default_nettype none
`include "usu_defines.vh"
module usu_monitor #(
  parameter DATA_W = 8,
  parameter CNT_W = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] wire_mode_select,
  input wire logic clock_toggle_strobe,
  input wire logic port_clock_toggle,
  input wire logic data_wr,
  input wire logic [DATA_W-1:0] data_wdata,
  input wire logic status_wr,
  input wire logic status_clear_ovf,
  input wire logic [CNT_W-1:0] status_cnt_value,
  input wire logic serial_clock_pin_out,
  input wire logic [DATA_W-1:0] shift_data_register,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic counter_overflow_flag,
  input wire logic wake_request,
  input wire logic rx_valid,
  input wire logic [DATA_W-1:0] rx_data,
  input wire logic rx_ready
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_wr;
    data_wr |=> shift_data_register == $past(data_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_ld;
    status_wr |=> counter_value == $past(status_cnt_value);
  endproperty
  a_ld: assert property (p_ld) else $error("count not loaded");
  property p_stk;
    counter_overflow_flag && !(status_wr && status_clear_ovf) |=> counter_overflow_flag;
  endproperty
  a_stk: assert property (p_stk) else $error("flag dropped");
  property p_ovf;
    $rose(counter_overflow_flag) |-> counter_value == 4'h0 && $past(counter_value) == 4'hf;
  endproperty
  a_ovf: assert property (p_ovf) else $error("flag without wrap");
  // One count per clock event, no jump except on a status load
  property p_step;
    !$past(status_wr) && counter_value != $past(counter_value)
      |-> counter_value - $past(counter_value) == 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_tgl;
    wire_mode_select == `USU_WM_THREE && clock_toggle_strobe && !port_clock_toggle
      |=> serial_clock_pin_out != $past(serial_clock_pin_out);
  endproperty
  a_tgl: assert property (p_tgl) else $error("clock not toggled");
  property p_wake;
    counter_overflow_flag [*2] |-> wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_rx;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_rx: assert property (p_rx) else $error("byte lost on stall");
  c_ovf: cover property ($rose(counter_overflow_flag));
  c_rx: cover property (rx_valid && rx_ready);
  c_stall: cover property (rx_valid && !rx_ready);
endmodule
bind usu_top usu_monitor #(.DATA_W(DATA_W), .CNT_W(CNT_W)) u_usu_monitor (
  .clk_sys, .nrst, .wire_mode_select, .clock_toggle_strobe, .port_clock_toggle,
  .data_wr, .data_wdata, .status_wr, .status_clear_ovf, .status_cnt_value,
  .serial_clock_pin_out, .shift_data_register, .counter_value,
  .counter_overflow_flag, .wake_request, .rx_valid, .rx_data, .rx_ready);
`default_nettype wire

// File: bench/usu_spi_master_model.sv
// Remote mode 0/1 master on the three-wire link
`timescale 1ns/1ps
`default_nettype none
module usu_spi_master_model (
  output logic sck,
  output logic mosi,
  input wire logic miso,
  output logic [7:0] rx_byte
);
  // ********
  // Frames: 400 ns period, clock still between frames
  // ********
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    rx_byte = 8'h00;
  end
  // Mode 0 samples on the rise, mode 1 on the fall; the long phase ends at the
  // sample edge because the unit's data out trails a pin edge by up to six cycles
  task automatic xfer(input logic [7:0] tx, input logic cpha);
    logic [7:0] sh;
    integer i;
    begin
      #7;
      sh = tx;
      mosi = sh[7];
      #250;
      for (i = 0; i < 8; i = i + 1) begin
        sck = 1'b1;
        if (cpha && i > 0)
          mosi = sh[7];
        if (!cpha)
          rx_byte = {rx_byte[6:0], miso};
        #(cpha ? 300 : 100);
        sck = 1'b0;
        if (cpha)
          rx_byte = {rx_byte[6:0], miso};
        sh = sh << 1;
        // Released line shows the inverse of its last bit
        if (!cpha || i == 7)
          mosi = (i < 7) ? sh[7] : ~mosi;
        #(cpha ? 100 : 300);
      end
    end
  endtask
  // Start condition: data line falls while the clock stands high
  task automatic start_cond;
    begin
      mosi = 1'b1;
      #200;
      sck = 1'b1;
      #200;
      mosi = 1'b0;
      #200;
      sck = 1'b0;
      #200;
      mosi = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// File: bench/test_universal_serial_three_wire.sv
// Self-checking bench for the serial shift unit
`timescale 1ns/1ps
`default_nettype none
`include "usu_defines.vh"
module test_universal_serial_three_wire;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] wire_mode_select = 2'h0;
  logic clock_source_select = 1'b0, clock_edge_select = 1'b0, clock_drive_enable = 1'b0;
  logic data_drive_enable = 1'b0, data_wr = 1'b0, status_wr = 1'b0, rx_ready = 1'b0;
  logic status_clear_ovf = 1'b1, status_clear_start = 1'b0;
  logic [3:0] pls = 4'h0;
  logic [7:0] data_wdata = 8'h00;
  logic [3:0] status_cnt_value = 4'h0;
  wire shift_clock_strobe, clock_toggle_strobe, timer_match, port_clock_toggle;
  wire serial_data_input_pin, serial_clock_pin_in, m_sck, m_miso, serial_clock_pin_out;
  wire serial_clock_pin_oe_n, data_out_pin, data_out_pin_oe_n, counter_overflow_flag;
  wire wake_request, rx_valid, start_condition_flag, sda_pin_oe_n;
  wire [7:0] shift_data_register, rx_data, m_rx;
  wire [3:0] counter_value;
  integer err_total = 0, checks_done = 0, cycles = 0, n = 0;
  assign {port_clock_toggle, timer_match, clock_toggle_strobe, shift_clock_strobe} = pls;
  // Device drives its own clock pin when enabled; otherwise the master does
  assign serial_clock_pin_in = serial_clock_pin_oe_n ? m_sck : serial_clock_pin_out;
  assign m_miso = data_out_pin_oe_n ? ~data_out_pin : data_out_pin;
  always #25 clk_sys = ~clk_sys;
  usu_top u_usu_top (.clk_sys, .nrst, .wire_mode_select, .clock_source_select,
    .clock_edge_select, .clock_toggle_strobe, .shift_clock_strobe, .timer_match,
    .port_clock_toggle, .clock_drive_enable, .data_drive_enable, .data_wr, .data_wdata,
    .status_wr, .status_clear_ovf, .status_clear_start, .status_cnt_value,
    .serial_data_input_pin, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe_n, .data_out_pin, .data_out_pin_oe_n, .sda_pin_oe_n,
    .shift_data_register, .counter_value, .counter_overflow_flag,
    .start_condition_flag, .wake_request, .rx_valid, .rx_data, .rx_ready);
  usu_spi_master_model u_usu_spi_master_model (.sck(m_sck),
    .mosi(serial_data_input_pin), .miso(m_miso), .rx_byte(m_rx));
  // ********
  // Access tasks
  // ********
  task automatic cyc(input integer k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic pulse(input logic [3:0] m);
    begin
      pls = pls | m;
      cyc(1);
      pls = pls & ~m;
      cyc(1);
    end
  endtask
  task automatic wr_data(input logic [7:0] v);
    begin
      data_wdata = v;
      data_wr = 1'b1;
      cyc(1);
      data_wr = 1'b0;
    end
  endtask
  task automatic wr_stat(input logic [3:0] v);
    begin
      status_cnt_value = v;
      status_wr = 1'b1;
      cyc(1);
      status_wr = 1'b0;
    end
  endtask
  task automatic end_of_test;
    begin
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  // Generous ceiling: the sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    cyc(5);
    nrst = 1'b1;
    cyc(4);
    chk(shift_data_register, 8'h00);
    chk(8'({counter_value, counter_overflow_flag, serial_clock_pin_oe_n}), 8'h01);
    wire_mode_select = `USU_WM_THREE;
    clock_source_select = 1'b1;
    data_drive_enable = 1'b1;
    wr_data(8'ha5);
    chk(shift_data_register, 8'ha5);
    wr_stat(4'h0);
    u_usu_spi_master_model.xfer(8'h3c, 1'b0);
    cyc(8);
    chk(shift_data_register, 8'h3c);
    chk(m_rx, 8'ha5);
    chk(8'({counter_value, counter_overflow_flag, rx_valid}), 8'h03);
    chk(rx_data, 8'h3c);
    rx_ready = 1'b1;
    cyc(1);
    rx_ready = 1'b0;
    // Mode 1: sample on the fall, output moves on the rise
    clock_edge_select = 1'b1;
    wr_data(8'h69);
    wr_stat(4'h0);
    u_usu_spi_master_model.xfer(8'h96, 1'b1);
    cyc(8);
    chk(shift_data_register, 8'h96);
    chk(m_rx, 8'h69);
    chk(8'({counter_value, counter_overflow_flag, rx_valid}), 8'h03);
    chk(rx_data, 8'h96);
    rx_ready = 1'b1;
    cyc(1);
    rx_ready = 1'b0;
    clock_edge_select = 1'b0;
    wr_stat(4'h9);
    chk(8'({counter_value, counter_overflow_flag}), 8'h12);
    clock_source_select = 1'b0;
    wr_data(8'h81);
    pulse(4'h1);
    chk(shift_data_register, 8'h03);
    chk(8'(counter_value), 8'h0a);
    clock_edge_select = 1'b1;
    pulse(4'h4);
    chk(8'({shift_data_register[3:0], counter_value}), 8'h7b);
    data_wdata = 8'h55;
    data_wr = 1'b1;
    pulse(4'h4);
    data_wr = 1'b0;
    chk(shift_data_register, 8'h55);
    clock_drive_enable = 1'b1;
    pulse(4'h2);
    chk(8'(serial_clock_pin_out), 8'h01);
    pulse(4'h8);
    chk(8'(serial_clock_pin_out), 8'h00);
    // Count on the toggle strobe, pin looped back through its own driver
    clock_source_select = 1'b1;
    clock_edge_select = 1'b0;
    wr_stat(4'h0);
    pls = 4'h1;
    repeat (16) begin
      pulse(4'h2);
      cyc(4);
    end
    pls = 4'h0;
    clock_drive_enable = 1'b0;
    chk(8'(counter_overflow_flag), 8'h01);
    chk(shift_data_register, 8'hff);
    // Half rate: toggle alone, then toggle with shift, every cycle
    clock_source_select = 1'b0;
    wr_data(8'h00);
    repeat (8) begin
      pls = 4'h2;
      cyc(1);
      pls = 4'h3;
      cyc(1);
    end
    pls = 4'h0;
    cyc(1);
    chk(shift_data_register, 8'hff);
    chk(8'({counter_value, serial_clock_pin_out}), 8'h10);
    // Fill the receive path while the reader stalls, then drain it
    clock_source_select = 1'b0;
    wr_stat(4'h0);
    repeat (96) pulse(4'h1);
    rx_ready = 1'b1;
    repeat (20) begin
      if (rx_valid === 1'b1) begin
        chk(rx_data, 8'hff);
        n = n + 1;
      end
      cyc(1);
    end
    chk(8'(n), 8'h04);
    // Two-wire: a start holds the clock low until software clears it
    wr_stat(4'h0);
    wire_mode_select = `USU_WM_TWO;
    u_usu_spi_master_model.start_cond;
    cyc(4);
    chk(8'({start_condition_flag, serial_clock_pin_oe_n, wake_request, data_out_pin_oe_n,
      sda_pin_oe_n}), 8'h17);
    status_clear_start = 1'b1;
    wr_stat(4'h0);
    status_clear_start = 1'b0;
    wr_data(8'h00);
    cyc(2);
    chk(8'({start_condition_flag, serial_clock_pin_oe_n, wake_request, sda_pin_oe_n}),
      8'h04);
    end_of_test;
  end
endmodule
`default_nettype wire
